/* lhm_pkg.sv */
// package with constants for the lpc host mailbox status flags
//***************************************************************
// Overview of operation
//***************************************************************
// Overview of operation
// - user bits: cpu read-write, host read-only
// - host input write latches address bit 2
// - command flag: 0 data, 1 command
// - input full: host write sets, cpu read clears
// - output full: cpu write sets, host read clears
// - cpu may only write 0 to clear flags
// - gate-a20 mode overrides channel-1 input full
// - channel-3 upper layout by enable and select
// - ch3 bidir input full on last register
// - ch3 bidir output full on last register
// - ch3 host write mode on first register
// - ch3 cpu write mode on first register
// - simultaneous first writes: host wins
// - ch4 bidir input full on last register
// - ch4 bidir output full on last register
// - ch4 host write mode on first register
// - ch4 cpu write mode on first register
// - status registers 8 bits, host-readable
package lhm_pkg;
   localparam int STAT_W = 8;
   localparam int CHAN_N = 4;
   localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
   // field positions
   localparam int BIT_OUT_FULL = 0;
   localparam int BIT_IN_FULL = 1;
   localparam int BIT_USER_LO = 2;
   localparam int BIT_CMD = 3;
   localparam int BIT_WM_CPU = 4;
   localparam int BIT_WM_HOST = 5;
   localparam int BIT_BI_OUT = 6;
   localparam int BIT_BI_IN = 7;
   localparam int USER_HI_LSB = 4;
   localparam int USER_HI_W = 4;
   localparam int ADDR_CMD_BIT = 2;
   // channel indices
   localparam int CH_ONE = 0;
   localparam int CH_TWO = 1;
   localparam int CH_THREE = 2;
   localparam int CH_FOUR = 3;
   localparam int CH_EXTRA = 4;
   localparam int CH_SEL_W = 3;
endpackage

/* lhm_chan_flags.sv */
// one channel's command, input-full and output-full flags
`timescale 1ns/100ps
module lhm_chan_flags (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // host side events
   input wire logic hostInWr,
   input wire logic hostCmdBit,
   input wire logic hostOutRd,
   // cpu side events
   input wire logic cpuInRd,
   input wire logic cpuOutWr,
   input wire logic cpuClrOut,
   // alternative input-full control
   input wire logic altMode,
   input wire logic altSet,
   input wire logic altClr,
   // flags
   output logic cmdFlag,
   output logic inFull,
   output logic outFull
);
   import lhm_pkg::*;
   logic setIn, clrIn;

   // select normal or alternative input-full events
   always_comb begin
      setIn = altMode ? altSet : hostInWr;
      clrIn = altMode ? altClr : cpuInRd;
   end

   // command flag latched from address bit
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmdFlag <= 1'b0;
      end else if (hostInWr) begin
         cmdFlag <= hostCmdBit;
      end
   end

   // input full, set wins over clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         inFull <= 1'b0;
      end else if (setIn) begin
         inFull <= 1'b1;
      end else if (clrIn) begin
         inFull <= 1'b0;
      end
   end

   // output full, set wins over clears
   always_ff @(posedge mclk) begin
      if (reset) begin
         outFull <= 1'b0;
      end else if (cpuOutWr) begin
         outFull <= 1'b1;
      end else if (hostOutRd || cpuClrOut) begin
         outFull <= 1'b0;
      end
   end
endmodule

/* lhm_bidir_flags.sv */
// bidirectional buffer flags with write-mode arbitration
`timescale 1ns/100ps
module lhm_bidir_flags (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // host side events
   input wire logic hostFirstWr,
   input wire logic hostLastWr,
   input wire logic hostLastRd,
   // cpu side events
   input wire logic cpuFirstWr,
   input wire logic cpuLastWr,
   input wire logic cpuLastRd,
   input wire logic cpuClrOut,
   input wire logic cpuClrWm,
   // flags
   output logic biInFull,
   output logic biOutFull,
   output logic hostWm,
   output logic cpuWm
);
   import lhm_pkg::*;
   logic hostGrant, cpuGrant;

   // arbitration: host has priority on same-cycle first writes
   always_comb begin
      hostGrant = hostFirstWr && !cpuWm;
      cpuGrant = cpuFirstWr && !hostWm && !hostFirstWr;
   end

   // bidirectional input full
   always_ff @(posedge mclk) begin
      if (reset) begin
         biInFull <= 1'b0;
      end else if (hostLastWr) begin
         biInFull <= 1'b1;
      end else if (cpuLastRd) begin
         biInFull <= 1'b0;
      end
   end

   // bidirectional output full
   always_ff @(posedge mclk) begin
      if (reset) begin
         biOutFull <= 1'b0;
      end else if (cpuLastWr) begin
         biOutFull <= 1'b1;
      end else if (hostLastRd || cpuClrOut) begin
         biOutFull <= 1'b0;
      end
   end

   // host write mode
   always_ff @(posedge mclk) begin
      if (reset) begin
         hostWm <= 1'b0;
      end else if (hostGrant) begin
         hostWm <= 1'b1;
      end else if (cpuLastRd) begin
         hostWm <= 1'b0;
      end
   end

   // cpu write mode
   always_ff @(posedge mclk) begin
      if (reset) begin
         cpuWm <= 1'b0;
      end else if (cpuGrant) begin
         cpuWm <= 1'b1;
      end else if (hostLastRd || cpuClrWm) begin
         cpuWm <= 1'b0;
      end
   end
endmodule

/* lhm_status_flags.sv */
// status registers of the lpc host mailbox channels
`timescale 1ns/100ps
module lhm_status_flags (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // host input register writes, per channel
   input wire logic [lhm_pkg::CHAN_N-1:0] hostInWr,
   input wire logic hostAddrBit2,
   // host output register reads, per channel
   input wire logic [lhm_pkg::CHAN_N-1:0] hostOutRd,
   // host status read
   input wire logic hostStatRd,
   input wire logic [lhm_pkg::CH_SEL_W-1:0] hostStatSel,
   // host bidirectional access, index 0 ch3, 1 ch4
   input wire logic [1:0] hostFirstWr,
   input wire logic [1:0] hostLastWr,
   input wire logic [1:0] hostLastRd,
   // cpu data register events, per channel
   input wire logic [lhm_pkg::CHAN_N-1:0] cpuInRd,
   input wire logic [lhm_pkg::CHAN_N-1:0] cpuOutWr,
   // cpu bidirectional access, index 0 ch3, 1 ch4
   input wire logic [1:0] cpuFirstWr,
   input wire logic [1:0] cpuLastWr,
   input wire logic [1:0] cpuLastRd,
   // cpu status register port
   input wire logic cpuStatWr,
   input wire logic [lhm_pkg::CH_SEL_W-1:0] cpuStatSel,
   input wire logic [lhm_pkg::STAT_W-1:0] cpuWrData,
   output logic [lhm_pkg::STAT_W-1:0] cpuStatData,
   // mode controls
   input wire logic bidirEnableChThree,
   input wire logic layoutSelectChThree,
   input wire logic bidirEnableChFour,
   // fast gate-a20 input-full override for channel 1
   input wire logic gateA20Mode,
   input wire logic gateA20Set,
   input wire logic gateA20Clr,
   // host status read data
   output logic [lhm_pkg::STAT_W-1:0] hostStatData,
   // flag outputs for cpu interrupt logic
   output logic [lhm_pkg::CHAN_N-1:0] inFull,
   output logic [lhm_pkg::CHAN_N-1:0] outFull,
   output logic [1:0] biInFull
);
   import lhm_pkg::*;

   //***************************************************************
   // declarations
   //***************************************************************
   logic [CHAN_N-1:0] cmdFlag;
   logic [CHAN_N-1:0] userLo_r;
   logic [USER_HI_W-1:0] userHi_r [CHAN_N];
   logic [CHAN_N-1:0] statWr;
   logic [CHAN_N-1:0] clrOut;
   logic [1:0] biOutFull, hostWm, cpuWm, clrBiOut, clrWm;
   logic [1:0] biFlagView;
   logic [STAT_W-1:0] stat [CHAN_N];
   logic [STAT_W-1:0] muxStat, muxCpu;

   //***************************************************************
   // cpu write decode
   //***************************************************************
   // a zero written to the output-full bit clears it, and to the bidir output-full or cpu write-mode bit while the bidir layout is shown; a one does nothing
   always_comb begin
      for (int i = 0; i < CHAN_N; i++) begin
         statWr[i] = cpuStatWr && (cpuStatSel == CH_SEL_W'(i));
         clrOut[i] = statWr[i] && !cpuWrData[BIT_OUT_FULL];
      end
      biFlagView[0] = bidirEnableChThree || !layoutSelectChThree;
      biFlagView[1] = bidirEnableChFour;
      for (int j = 0; j < 2; j++) begin
         clrBiOut[j] = statWr[CH_THREE + j] && biFlagView[j]
            && !cpuWrData[BIT_BI_OUT];
         clrWm[j] = statWr[CH_THREE + j] && biFlagView[j]
            && !cpuWrData[BIT_WM_CPU];
      end
   end

   //***************************************************************
   // channel flag instances
   //***************************************************************
   genvar g;
   generate
      for (g = 0; g < CHAN_N; g++) begin : gChan
         lhm_chan_flags uChan (
            .mclk(mclk),
            .reset(reset),
            .hostInWr(hostInWr[g]),
            .hostCmdBit(hostAddrBit2),
            .hostOutRd(hostOutRd[g]),
            .cpuInRd(cpuInRd[g]),
            .cpuOutWr(cpuOutWr[g]),
            .cpuClrOut(clrOut[g]),
            .altMode((g == CH_ONE) ? gateA20Mode : 1'b0),
            .altSet(gateA20Set),
            .altClr(gateA20Clr),
            .cmdFlag(cmdFlag[g]),
            .inFull(inFull[g]),
            .outFull(outFull[g])
         );
      end
      for (g = 0; g < 2; g++) begin : gBidir
         lhm_bidir_flags uBidir (
            .mclk(mclk),
            .reset(reset),
            .hostFirstWr(hostFirstWr[g]),
            .hostLastWr(hostLastWr[g]),
            .hostLastRd(hostLastRd[g]),
            .cpuFirstWr(cpuFirstWr[g]),
            .cpuLastWr(cpuLastWr[g]),
            .cpuLastRd(cpuLastRd[g]),
            .cpuClrOut(clrBiOut[g]),
            .cpuClrWm(clrWm[g]),
            .biInFull(biInFull[g]),
            .biOutFull(biOutFull[g]),
            .hostWm(hostWm[g]),
            .cpuWm(cpuWm[g])
         );
      end
   endgenerate

   //***************************************************************
   // user-defined bits
   //***************************************************************
   // lower user bit, cpu writable only
   always_ff @(posedge mclk) begin
      if (reset) begin
         userLo_r <= '0;
      end else begin
         for (int i = 0; i < CHAN_N; i++) begin
            if (statWr[i]) begin
               userLo_r[i] <= cpuWrData[BIT_USER_LO];
            end
         end
      end
   end

   // upper user bits, written only while the user layout is shown
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < CHAN_N; i++) begin
            userHi_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CHAN_N; i++) begin
            if (statWr[i] && !((i == CH_THREE) && biFlagView[0])
                && !((i == CH_FOUR) && biFlagView[1])) begin
               userHi_r[i] <= cpuWrData[STAT_W-1:USER_HI_LSB];
            end
         end
      end
   end

   //***************************************************************
   // status assembly and read paths
   //***************************************************************
   // compose each channel's status byte from the current layout
   always_comb begin
      for (int i = 0; i < CHAN_N; i++) begin
         stat[i] = {userHi_r[i], cmdFlag[i], userLo_r[i],
                    inFull[i], outFull[i]};
      end
      for (int j = 0; j < 2; j++) begin
         if (biFlagView[j]) begin
            stat[CH_THREE + j][STAT_W-1:USER_HI_LSB] =
               {biInFull[j], biOutFull[j], hostWm[j], cpuWm[j]};
         end
      end
   end

   // host and cpu read muxes; the extra channel lies outside this block
   always_comb begin
      muxStat = STAT_RESET;
      if (hostStatSel < CH_SEL_W'(CHAN_N)) begin
         muxStat = stat[hostStatSel[1:0]];
      end
      muxCpu = STAT_RESET;
      if (cpuStatSel < CH_SEL_W'(CHAN_N)) begin
         muxCpu = stat[cpuStatSel[1:0]];
      end
   end

   // registered read data for host and cpu
   always_ff @(posedge mclk) begin
      if (reset) begin
         hostStatData <= STAT_RESET;
         cpuStatData <= STAT_RESET;
      end else begin
         if (hostStatRd) begin
            hostStatData <= muxStat;
         end
         cpuStatData <= muxCpu;
      end
   end

   //***************************************************************
   // assertions
   //***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   cmd_latch_a: assert property (hostInWr[CH_TWO] |=>
      cmdFlag[CH_TWO] == $past(hostAddrBit2))
      else $error("command flag not latched from address");
   in_full_set_a: assert property (hostInWr[CH_TWO] |=>
      inFull[CH_TWO]) else $error("input full not set");
   in_full_clr_a: assert property (
      cpuInRd[CH_TWO] && !hostInWr[CH_TWO] |=> !inFull[CH_TWO])
      else $error("input full not cleared");
   out_one_keep_a: assert property (
      statWr[CH_TWO] && cpuWrData[BIT_OUT_FULL] && outFull[CH_TWO]
      && !hostOutRd[CH_TWO] |=> outFull[CH_TWO])
      else $error("writing one changed output full");
   out_full_clr_a: assert property (
      hostOutRd[CH_TWO] && !cpuOutWr[CH_TWO] |=> !outFull[CH_TWO])
      else $error("host read did not clear output full");
   layout_three_a: assert property (biFlagView[0] |->
      stat[CH_THREE][BIT_WM_HOST] == hostWm[0])
      else $error("channel three layout wrong");
   host_prio_a: assert property (
      hostFirstWr[0] && cpuFirstWr[0] && !cpuWm[0] && !hostWm[0]
      |=> hostWm[0] && !cpuWm[0])
      else $error("host did not win first register");
   bi_in_set_a: assert property (hostLastWr[1] |=>
      biInFull[1]) else $error("ch4 bidir input full not set");
   wm_excl_a: assert property (!(hostWm[0] && cpuWm[0]))
      else $error("both write modes set");
   host_read_a: assert property (hostStatRd && hostStatSel ==
      CH_SEL_W'(CH_ONE) |=> hostStatData == $past(stat[CH_ONE]))
      else $error("host status read wrong");

   // channel one command and input flags
   cmd_one_a: assert property (hostInWr[CH_ONE] |=>
      cmdFlag[CH_ONE] == $past(hostAddrBit2))
      else $error("ch1 command flag wrong");
   in_one_set_a: assert property (
      !gateA20Mode && hostInWr[CH_ONE] |=> inFull[CH_ONE])
      else $error("ch1 input full not set");

   // fast gate-a20 override of channel one input full
   a20_set_a: assert property (gateA20Mode && gateA20Set |=>
      inFull[CH_ONE]) else $error("gate-a20 set ignored");
   a20_clr_a: assert property (
      gateA20Mode && gateA20Clr && !gateA20Set |=> !inFull[CH_ONE])
      else $error("gate-a20 clear ignored");
   a20_keep_a: assert property (
      gateA20Mode && !gateA20Set && !gateA20Clr
      |=> $stable(inFull[CH_ONE]))
      else $error("ch1 input full moved");

   // output full set and clear paths
   out_set_a: assert property (cpuOutWr[CH_TWO] |=>
      outFull[CH_TWO]) else $error("output full not set");
   out_zero_a: assert property (
      statWr[CH_ONE] && !cpuWrData[BIT_OUT_FULL] && !cpuOutWr[CH_ONE]
      |=> !outFull[CH_ONE]) else $error("zero write kept output full");

   // user-defined bits follow cpu writes
   user_lo_a: assert property (statWr[CH_TWO] |=>
      stat[CH_TWO][BIT_USER_LO] == $past(cpuWrData[BIT_USER_LO]))
      else $error("lower user bit not written");
   user_hi_a: assert property (statWr[CH_ONE] |=>
      stat[CH_ONE][STAT_W-1:USER_HI_LSB]
      == $past(cpuWrData[STAT_W-1:USER_HI_LSB]))
      else $error("upper user bits not written");

   // upper nibble layout of channels three and four
   user_three_a: assert property (
      !bidirEnableChThree && layoutSelectChThree
      |-> stat[CH_THREE][STAT_W-1:USER_HI_LSB] == userHi_r[CH_THREE])
      else $error("ch3 user layout wrong");
   layout_four_a: assert property (bidirEnableChFour |->
      stat[CH_FOUR][BIT_BI_IN] == biInFull[1])
      else $error("ch4 bidir layout wrong");
   user_four_a: assert property (!bidirEnableChFour |->
      stat[CH_FOUR][STAT_W-1:USER_HI_LSB] == userHi_r[CH_FOUR])
      else $error("ch4 user layout wrong");
   hidden_keep_a: assert property (bidirEnableChFour |=>
      $stable(userHi_r[CH_FOUR])) else $error("hidden user bits written");

   // bidirectional full flags of both channels
   bi_in3_set_a: assert property (hostLastWr[0] |=>
      biInFull[0]) else $error("ch3 bidir input full not set");
   bi_in3_clr_a: assert property (
      cpuLastRd[0] && !hostLastWr[0] |=> !biInFull[0])
      else $error("ch3 bidir input full not cleared");
   bi_in4_clr_a: assert property (
      cpuLastRd[1] && !hostLastWr[1] |=> !biInFull[1])
      else $error("ch4 bidir input full not cleared");
   bi_out3_set_a: assert property (cpuLastWr[0] |=>
      biOutFull[0]) else $error("ch3 bidir output full not set");
   bi_out3_clr_a: assert property (
      hostLastRd[0] && !cpuLastWr[0] |=> !biOutFull[0])
      else $error("ch3 bidir output full not cleared");
   bi_out4_clr_a: assert property (
      hostLastRd[1] && !cpuLastWr[1] |=> !biOutFull[1])
      else $error("ch4 bidir output full not cleared");

   // write-mode grants and releases
   host_wm3_a: assert property (hostFirstWr[0] && !cpuWm[0] |=>
      hostWm[0]) else $error("ch3 host write mode not set");
   host_wm3_clr_a: assert property (
      cpuLastRd[0] && !hostFirstWr[0] |=> !hostWm[0])
      else $error("ch3 host write mode not cleared");
   host_wm4_a: assert property (hostFirstWr[1] && !cpuWm[1] |=>
      hostWm[1]) else $error("ch4 host write mode not set");
   cpu_wm3_a: assert property (
      cpuFirstWr[0] && !hostWm[0] && !hostFirstWr[0] |=> cpuWm[0])
      else $error("ch3 cpu write mode not set");
   cpu_wm3_clr_a: assert property (
      hostLastRd[0] && !cpuFirstWr[0] |=> !cpuWm[0])
      else $error("ch3 cpu write mode not cleared");
   cpu_wm4_a: assert property (
      cpuFirstWr[1] && !hostWm[1] && !hostFirstWr[1] |=> cpuWm[1])
      else $error("ch4 cpu write mode not set");
   cpu_refuse_a: assert property (cpuFirstWr[1] && hostWm[1] |=>
      !cpuWm[1]) else $error("ch4 cpu granted in host mode");
   host_prio4_a: assert property (
      hostFirstWr[1] && cpuFirstWr[1] && !cpuWm[1]
      |=> hostWm[1] && !cpuWm[1])
      else $error("host did not win ch4 first register");
   wm_one_keep_a: assert property (
      statWr[CH_THREE] && cpuWrData[BIT_WM_CPU] && cpuWm[0]
      && !hostLastRd[0] |=> cpuWm[0])
      else $error("writing one changed cpu write mode");

   // reset values and status read paths
   reset_zero_a: assert property (disable iff (1'b0) reset |=>
      {stat[CH_ONE], stat[CH_TWO], stat[CH_THREE], stat[CH_FOUR]} == 32'h0
      && {biOutFull, hostWm, cpuWm, biInFull} == 8'h00
      && {userHi_r[CH_THREE], userHi_r[CH_FOUR]} == 8'h00
      && hostStatData == STAT_RESET && cpuStatData == STAT_RESET)
      else $error("status not cleared by reset");
   host_extra_a: assert property (hostStatRd && hostStatSel ==
      CH_SEL_W'(CH_EXTRA) |=> hostStatData == STAT_RESET)
      else $error("extra channel read not zero");
   host_hold_a: assert property (!hostStatRd |=>
      $stable(hostStatData)) else $error("host read data moved");
   cpu_read_a: assert property (cpuStatSel == CH_SEL_W'(CH_FOUR) |=>
      cpuStatData == $past(stat[CH_FOUR]))
      else $error("cpu status read wrong");

   cover_cmd_c: cover property (hostInWr[CH_ONE] && hostAddrBit2);
   cover_prio_c: cover property (hostFirstWr[0] && cpuFirstWr[0]);
   cover_bi4_c: cover property (cpuLastWr[1] ##1 hostLastRd[1]);
   cover_a20_c: cover property (gateA20Mode && gateA20Set);
   cover_refuse_c: cover property (cpuFirstWr[1] && hostWm[1]);
endmodule

/* lhm_host_model.sv */
// lpc host model issuing i/o cycles to the mailbox
`timescale 1ns/100ps
module lhm_host_model (
   // clock
   input wire logic mclk,
   // status read data from the device
   input wire logic [lhm_pkg::STAT_W-1:0] hostStatData,
   // i/o cycle strobes
   output logic [lhm_pkg::CHAN_N-1:0] hostInWr,
   output logic hostAddrBit2,
   output logic [lhm_pkg::CHAN_N-1:0] hostOutRd,
   output logic hostStatRd,
   output logic [lhm_pkg::CH_SEL_W-1:0] hostStatSel,
   // bidirectional accesses
   output logic [1:0] hostFirstWr,
   output logic [1:0] hostLastWr,
   output logic [1:0] hostLastRd
);
   import lhm_pkg::*;
   // ********
   // cycles
   // ********
   initial begin
      {hostInWr, hostAddrBit2, hostOutRd, hostStatRd, hostStatSel} = '0;
      {hostFirstWr, hostLastWr, hostLastRd} = '0;
   end
   // one cycle, optionally after idle gap cycles
   task automatic hostOp(input int op, ch, ha, gap,
                         output logic [STAT_W-1:0] rd);
      repeat (gap) @(negedge mclk);
      @(negedge mclk);
      case (op)
         0: begin
            hostInWr[ch] = 1'b1;
            hostAddrBit2 = ha[0];
         end
         1: hostOutRd[ch] = 1'b1;
         2: begin
            hostStatRd = 1'b1;
            hostStatSel = ch[2:0];
         end
         3: hostFirstWr[ch] = 1'b1;
         4: hostLastWr[ch] = 1'b1;
         5: hostLastRd[ch] = 1'b1;
         default: ;
      endcase
      @(negedge mclk);
      rd = hostStatData;
      {hostInWr, hostOutRd, hostStatRd} = '0;
      {hostFirstWr, hostLastWr, hostLastRd} = '0;
      // released address lines do not keep their value
      hostAddrBit2 = ~hostAddrBit2;
      hostStatSel = ~hostStatSel;
   endtask
endmodule

/* tb_lhm_status_flags.sv */
// self-checking bench for the mailbox status flags
`timescale 1ns/100ps
module tb_lhm_status_flags;
   import lhm_pkg::*;
   // ********
   // signals
   // ********
   logic mclk, reset, hostAddrBit2, hostStatRd, cpuStatWr;
   logic [3:0] hostInWr, hostOutRd, cpuInRd, cpuOutWr, inFull, outFull;
   logic [2:0] hostStatSel, cpuStatSel;
   logic [1:0] hostFirstWr, hostLastWr, hostLastRd, biInFull;
   logic [1:0] cpuFirstWr, cpuLastWr, cpuLastRd;
   logic [7:0] cpuWrData, cpuStatData, hostStatData;
   logic bidirEnableChThree, layoutSelectChThree, bidirEnableChFour;
   logic gateA20Mode, gateA20Set, gateA20Clr;
   int errors, checks, seed;
   // expected state
   logic [3:0] cmdE, inE, outE, loE;
   logic [3:0] hiE [4];
   logic [1:0] biInE, biOutE, hWmE, cWmE;
   int hops[3] = '{0, 1, 6};
   int cops[4] = '{0, 1, 2, 8};
   int tA[5][7] = '{'{0,1,1,0,1,0,1}, '{1,0,0,1,0,0,0},
      '{6,0,0,2,0,8'hff,0}, '{6,0,0,2,0,8'h00,0}, '{0,3,0,8,0,0,3}};
   int tG[4][7] = '{'{0,0,1,8,0,0,0}, '{6,0,0,6,0,0,0},
      '{6,0,0,0,0,0,0}, '{6,0,0,7,0,0,0}};
   int tB[12][3] = '{'{3,3,0}, '{6,3,0}, '{4,8,0}, '{6,5,0}, '{6,3,0},
      '{3,8,0}, '{6,4,0}, '{5,4,0}, '{6,3,0}, '{6,2,8'hff},
      '{6,2,8'h0a}, '{4,8,0}};

   lhm_status_flags uut (.mclk, .reset, .hostInWr, .hostAddrBit2,
      .hostOutRd, .hostStatRd, .hostStatSel, .hostFirstWr, .hostLastWr,
      .hostLastRd, .cpuInRd, .cpuOutWr, .cpuFirstWr, .cpuLastWr,
      .cpuLastRd, .cpuStatWr, .cpuStatSel, .cpuWrData, .cpuStatData,
      .bidirEnableChThree, .layoutSelectChThree, .bidirEnableChFour,
      .gateA20Mode, .gateA20Set, .gateA20Clr, .hostStatData, .inFull,
      .outFull, .biInFull);

   lhm_host_model host (.mclk, .hostStatData, .hostInWr, .hostAddrBit2,
      .hostOutRd, .hostStatRd, .hostStatSel, .hostFirstWr, .hostLastWr,
      .hostLastRd);

   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      tally_and_finish();
   end
   // ********
   // expectation
   // ********
   function automatic logic bid(int c);
      if (c == 2) return bidirEnableChThree | ~layoutSelectChThree;
      return c == 3 ? bidirEnableChFour : 1'b0;
   endfunction
   function automatic logic [7:0] expStat(int c);
      if (c > 3) return 8'h00;
      return {bid(c) ? {biInE[c[0]], biOutE[c[0]], hWmE[c[0]],
         cWmE[c[0]]} : hiE[c], cmdE[c], loE[c], inE[c], outE[c]};
   endfunction
   function automatic void clr();
      {cmdE, inE, outE, loE, biInE, biOutE, hWmE, cWmE} = '0;
      foreach (hiE[i]) hiE[i] = 4'h0;
   endfunction
   // applies one host and one cpu event, set wins over clear
   function automatic void upd(int ho, hc, ha, co, cc, d);
      for (int c = 0; c < 4; c++) begin
         logic sw;
         sw = co == 2 && cc == c;
         if (ho == 0 && hc == c) cmdE[c] = ha[0];
         if (c == 0 && gateA20Mode)
            inE[0] = co == 6 ? 1'b1 : (co == 7 ? 1'b0 : inE[0]);
         else if (ho == 0 && hc == c) inE[c] = 1'b1;
         else if (co == 0 && cc == c) inE[c] = 1'b0;
         if (co == 1 && cc == c) outE[c] = 1'b1;
         else if ((ho == 1 && hc == c) || (sw && !d[0])) outE[c] = 1'b0;
         if (sw) loE[c] = d[2];
         if (sw && !bid(c)) hiE[c] = d[7:4];
      end
      for (int k = 0; k < 2; k++) begin
         logic sw, gh;
         sw = co == 2 && cc == k + 2 && bid(k + 2);
         gh = ho == 3 && hc == k && !cWmE[k];
         if (co == 3 && cc == k && !hWmE[k] && !gh) cWmE[k] = 1'b1;
         else if ((ho == 5 && hc == k) || (sw && !d[4])) cWmE[k] = 1'b0;
         if (gh) hWmE[k] = 1'b1;
         else if (co == 5 && cc == k) hWmE[k] = 1'b0;
         if (ho == 4 && hc == k) biInE[k] = 1'b1;
         else if (co == 5 && cc == k) biInE[k] = 1'b0;
         if (co == 4 && cc == k) biOutE[k] = 1'b1;
         else if ((ho == 5 && hc == k) || (sw && !d[6])) biOutE[k] = 1'b0;
      end
   endfunction
   // ********
   // drivers and checks
   // ********
   task automatic chk(input string nm, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cpuOp(input int op, ch, d);
      @(negedge mclk);
      case (op)
         0: cpuInRd[ch] = 1'b1;
         1: cpuOutWr[ch] = 1'b1;
         2: {cpuStatWr, cpuStatSel, cpuWrData} = {1'b1, ch[2:0], d[7:0]};
         3: cpuFirstWr[ch] = 1'b1;
         4: cpuLastWr[ch] = 1'b1;
         5: cpuLastRd[ch] = 1'b1;
         6: gateA20Set = 1'b1;
         7: gateA20Clr = 1'b1;
         default: ;
      endcase
      @(negedge mclk);
      {cpuInRd, cpuOutWr, cpuFirstWr, cpuLastWr, cpuLastRd} = '0;
      {cpuStatWr, gateA20Set, gateA20Clr} = '0;
      cpuWrData = ~cpuWrData;
   endtask
   task automatic look(input int c);
      logic [7:0] rd;
      fork
         host.hostOp(2, c, 1, 0, rd);
         begin
            @(negedge mclk);
            cpuStatSel = c[2:0];
            @(negedge mclk);
         end
      join
      chk("hostStat", expStat(c), rd);
      if (c < 4) chk("cpuStat", expStat(c), cpuStatData);
   endtask
   task automatic step(input int ho, hc, ha, co, cc, d, lk);
      logic [7:0] rd;
      fork
         host.hostOp(ho, hc, ha, co == 8 ? 2 : 0, rd);
         cpuOp(co, cc, d);
      join
      upd(ho, hc, ha, co, cc, d);
      chk("inFull", {4'h0, inE}, {4'h0, inFull});
      chk("outFull", {4'h0, outE}, {4'h0, outFull});
      chk("biInFull", {6'h00, biInE}, {6'h00, biInFull});
      look(lk);
   endtask
   task automatic rstChk(input int n);
      reset = 1'b1;
      repeat (n) @(negedge mclk);
      reset = 1'b0;
      clr();
      for (int m = 0; m < 2; m++) begin
         {bidirEnableChThree, bidirEnableChFour} = {m[0], m[0]};
         for (int c = 0; c < 5; c++) look(c);
      end
      {bidirEnableChThree, bidirEnableChFour} = 2'b00;
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ********
   // main sequence
   // ********
   initial begin
      seed = 32'he053;
      {errors, checks} = '0;
      {cpuInRd, cpuOutWr, cpuFirstWr, cpuLastWr, cpuLastRd} = '0;
      {cpuStatWr, cpuStatSel, cpuWrData} = '0;
      {gateA20Mode, gateA20Set, gateA20Clr, bidirEnableChFour} = '0;
      {bidirEnableChThree, layoutSelectChThree} = 2'b01;
      rstChk(20);
      foreach (tA[i]) step(tA[i][0], tA[i][1], tA[i][2], tA[i][3],
         tA[i][4], tA[i][5], tA[i][6]);
      repeat (150) step(hops[$unsigned($random(seed)) % 3],
         $unsigned($random(seed)) % 4, $random(seed) & 1,
         cops[$unsigned($random(seed)) % 4], $unsigned($random(seed)) % 4,
         $random(seed) & 8'hff, $unsigned($random(seed)) % 5);
      step(6, 0, 0, 0, 0, 0, 0);
      gateA20Mode = 1'b1;
      foreach (tG[i]) step(tG[i][0], tG[i][1], tG[i][2], tG[i][3],
         tG[i][4], tG[i][5], tG[i][6]);
      gateA20Mode = 1'b0;
      {bidirEnableChThree, bidirEnableChFour} = 2'b11;
      for (int k = 0; k < 2; k++)
         foreach (tB[i]) step(tB[i][0], k, 0, tB[i][1],
            tB[i][1] == 2 ? k + 2 : k, tB[i][2],
            k + 2);
      for (int m = 0; m < 4; m++) begin
         @(negedge mclk);
         {bidirEnableChThree, layoutSelectChThree} = m[1:0];
         bidirEnableChFour = m[0];
         look(2);
         look(3);
      end
      rstChk(3);
      tally_and_finish();
   end
endmodule
